// ==== logic/ses_status_top.sv ====
// status reporting hierarchy: lower registers, status byte and service request
//
// Notes on behaviour
// - rising live bit latches when rise filter set
// - falling live bit latches when fall filter set
// - filter parts read and write freely
// - latch keeps filtered transitions until read or clear-status
// - latch is read-only, cleared by read
// - sum bit is OR of latch AND mask
// - sum mask read and write freely
// - sum bit feeds next higher live state
// - byte bit 6 summarises other enabled bits
// - request mask bit 6 ignored
// - enabled byte bit rising issues request
// - byte bit 2 tracks error queue entries
// - byte bit 3 is doubtful-state summary
// - byte bit 4 while output pending
// - byte bit 5 is standard event summary
// - byte bit 7 is activity summary
// - byte answered by query and poll
// - lower parts 16 bits, bit 15 zero
// - live state read-only, read never clears
// - one bit position across all parts
`timescale 1ns/100ps
module ses_status_top
  import ses_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // hardware status sources, same clock domain
  input  wire logic [SR_W-1:0]       oper_hw,
  input  wire logic [SR_W-1:0]       ques_hw,
  input  wire logic [STD_W-1:0]      std_event_set,
  input  wire logic                  error_pending,
  input  wire logic                  output_pending,
  // command port
  input  wire logic                  cmd_valid,
  input  wire ses_pkg::ses_op_t      cmd_op,
  input  wire ses_pkg::ses_sel_t     cmd_sel,
  input  wire logic [SR_W-1:0]       cmd_wdata,
  output logic                       rsp_valid,
  output logic      [SR_W-1:0]       rsp_data,
  // serial poll
  input  wire logic                  poll_req,
  output logic                       poll_valid,
  output logic      [STB_W-1:0]      poll_data,
  // summary outputs
  output logic      [STB_W-1:0]      status_byte,
  output logic                       service_req
);

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic is_read;
  logic is_write;
  logic is_clear;
  logic is_preset;

  assign is_read   = cmd_valid && (cmd_op == OP_READ);
  assign is_write  = cmd_valid && (cmd_op == OP_WRITE);
  assign is_clear  = cmd_valid && (cmd_op == OP_CLEAR);
  assign is_preset = cmd_valid && (cmd_op == OP_PRESET);

  function automatic logic wr_hit(input logic wr, input ses_sel_t sel, input ses_sel_t want);
    wr_hit = wr && (sel == want);
  endfunction

  // ------------------------------------------------------------
  // per-register strobes
  // ------------------------------------------------------------
  logic wr_oper_rise;
  logic wr_oper_fall;
  logic wr_oper_mask;
  logic wr_ques_rise;
  logic wr_ques_fall;
  logic wr_ques_mask;
  logic wr_std_mask;
  logic wr_req_mask;
  logic clr_oper_event;
  logic clr_ques_event;
  logic clr_std_event;

  // writes to live state, latches and the byte have no strobe at all
  assign wr_oper_rise   = wr_hit(is_write, cmd_sel, SEL_OPER_RISE);
  assign wr_oper_fall   = wr_hit(is_write, cmd_sel, SEL_OPER_FALL);
  assign wr_oper_mask   = wr_hit(is_write, cmd_sel, SEL_OPER_MASK);
  assign wr_ques_rise   = wr_hit(is_write, cmd_sel, SEL_QUES_RISE);
  assign wr_ques_fall   = wr_hit(is_write, cmd_sel, SEL_QUES_FALL);
  assign wr_ques_mask   = wr_hit(is_write, cmd_sel, SEL_QUES_MASK);
  assign wr_std_mask    = wr_hit(is_write, cmd_sel, SEL_STD_MASK);
  assign wr_req_mask    = wr_hit(is_write, cmd_sel, SEL_REQUEST_MASK);
  // clear-status empties every latch; a read empties just the one read
  assign clr_oper_event = wr_hit(is_read, cmd_sel, SEL_OPER_EVENT) || is_clear;
  assign clr_ques_event = wr_hit(is_read, cmd_sel, SEL_QUES_EVENT) || is_clear;
  assign clr_std_event  = wr_hit(is_read, cmd_sel, SEL_STD_EVENT) || is_clear;

  // ------------------------------------------------------------
  // lower-level registers
  // ------------------------------------------------------------
  logic [SR_W-1:0]  oper_cond;
  logic [SR_W-1:0]  oper_event;
  logic [SR_W-1:0]  oper_rise;
  logic [SR_W-1:0]  oper_fall;
  logic [SR_W-1:0]  oper_mask;
  logic             oper_sum;
  logic [SR_W-1:0]  ques_cond;
  logic [SR_W-1:0]  ques_event;
  logic [SR_W-1:0]  ques_rise;
  logic [SR_W-1:0]  ques_fall;
  logic [SR_W-1:0]  ques_mask;
  logic             ques_sum;
  logic [STD_W-1:0] std_event;
  logic [STD_W-1:0] std_mask;
  logic             std_summary;

  // clear-status empties every latch; a read empties just the one read
  ses_status_reg u_oper (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .cond_in     (oper_hw),
    .wdata       (cmd_wdata),
    .wr_rise     (wr_oper_rise),
    .wr_fall     (wr_oper_fall),
    .wr_mask     (wr_oper_mask),
    .preset      (is_preset),
    .clear_event (clr_oper_event),
    .cond        (oper_cond),
    .event_bits  (oper_event),
    .rise_filter (oper_rise),
    .fall_filter (oper_fall),
    .sum_mask    (oper_mask),
    .sum_bit     (oper_sum)
  );

  ses_status_reg u_ques (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .cond_in     (ques_hw),
    .wdata       (cmd_wdata),
    .wr_rise     (wr_ques_rise),
    .wr_fall     (wr_ques_fall),
    .wr_mask     (wr_ques_mask),
    .preset      (is_preset),
    .clear_event (clr_ques_event),
    .cond        (ques_cond),
    .event_bits  (ques_event),
    .rise_filter (ques_rise),
    .fall_filter (ques_fall),
    .sum_mask    (ques_mask),
    .sum_bit     (ques_sum)
  );

  ses_std_event u_std (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .event_set   (std_event_set),
    .wdata       (cmd_wdata[STD_W-1:0]),
    .wr_mask     (wr_std_mask),
    .clear_event (clr_std_event),
    .event_bits  (std_event),
    .event_mask  (std_mask),
    .sum_bit     (std_summary)
  );

  // ------------------------------------------------------------
  // request mask
  // ------------------------------------------------------------
  logic [STB_W-1:0] request_mask_reg;

  // bit 6 is stored as zero so it can never gate anything
  always_ff @(posedge ref_clk) begin
    if (sys_rst) request_mask_reg <= BYTE_ZERO;
    else if (wr_req_mask)
      request_mask_reg <= cmd_wdata[STB_W-1:0] & REQ_USED;
  end

  // ------------------------------------------------------------
  // status byte assembly
  // ------------------------------------------------------------
  logic [STB_W-1:0] byte_low;
  logic [STB_W-1:0] byte_low_prev_reg;
  logic             top_summary;
  logic [STB_W-1:0] status_byte_next;
  logic [STB_W-1:0] status_byte_reg;
  logic             service_req_reg;

  always_comb begin
    byte_low               = BYTE_ZERO;
    byte_low[STB_ERR_BIT]  = error_pending;
    byte_low[STB_QUES_BIT] = ques_sum;
    byte_low[STB_OUT_BIT]  = output_pending;
    byte_low[STB_STD_BIT]  = std_summary;
    byte_low[STB_OPER_BIT] = oper_sum;
  end

  assign top_summary = |(byte_low & request_mask_reg);

  always_comb begin
    status_byte_next              = byte_low;
    status_byte_next[STB_TOP_BIT] = top_summary;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) status_byte_reg <= BYTE_ZERO;
    else status_byte_reg <= status_byte_next;
  end

  // request on any enabled bit going 0 to 1, one-cycle pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      byte_low_prev_reg <= BYTE_ZERO;
      service_req_reg   <= 1'b0;
    end else begin
      byte_low_prev_reg <= byte_low;
      service_req_reg   <= |(byte_low & ~byte_low_prev_reg & request_mask_reg);
    end
  end

  // ------------------------------------------------------------
  // read response
  // ------------------------------------------------------------
  logic [SR_W-1:0] rd_value;
  logic [SR_W-1:0] rsp_data_reg;
  logic            rsp_valid_reg;

  // value seen is the one before any clear caused by this read
  always_comb begin
    rd_value = SR_ZERO;
    unique case (cmd_sel)
      SEL_OPER_COND:    rd_value = oper_cond;
      SEL_OPER_EVENT:   rd_value = oper_event;
      SEL_OPER_RISE:    rd_value = oper_rise;
      SEL_OPER_FALL:    rd_value = oper_fall;
      SEL_OPER_MASK:    rd_value = oper_mask;
      SEL_QUES_COND:    rd_value = ques_cond;
      SEL_QUES_EVENT:   rd_value = ques_event;
      SEL_QUES_RISE:    rd_value = ques_rise;
      SEL_QUES_FALL:    rd_value = ques_fall;
      SEL_QUES_MASK:    rd_value = ques_mask;
      SEL_STD_EVENT:    rd_value = {BYTE_ZERO, std_event};
      SEL_STD_MASK:     rd_value = {BYTE_ZERO, std_mask};
      SEL_STATUS_BYTE:  rd_value = {BYTE_ZERO, status_byte_reg};
      SEL_REQUEST_MASK: rd_value = {BYTE_ZERO, request_mask_reg};
      default:          rd_value = SR_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= SR_ZERO;
    end else begin
      rsp_valid_reg <= is_read;
      if (is_read) rsp_data_reg <= rd_value;
    end
  end

  // ------------------------------------------------------------
  // serial poll
  // ------------------------------------------------------------
  logic             poll_valid_reg;
  logic [STB_W-1:0] poll_data_reg;

  // poll never clears anything, unlike an event read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      poll_valid_reg <= 1'b0;
      poll_data_reg  <= BYTE_ZERO;
    end else begin
      poll_valid_reg <= poll_req;
      if (poll_req) poll_data_reg <= status_byte_reg;
    end
  end

  assign rsp_valid   = rsp_valid_reg;
  assign rsp_data    = rsp_data_reg;
  assign poll_valid  = poll_valid_reg;
  assign poll_data   = poll_data_reg;
  assign status_byte = status_byte_reg;
  assign service_req = service_req_reg;

endmodule

// ==== logic/ses_pkg.sv ====
// shared constants and types for the status event summary block
package ses_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int SR_W  = 16;
  localparam int STB_W = 8;
  localparam int STD_W = 8;

  // bit 15 of every lower-level part always reads zero
  localparam logic [SR_W-1:0] SR_USED = 16'h7fff;
  localparam logic [SR_W-1:0] SR_ZERO = 16'h0000;

  // preset values applied by the preset operation
  localparam logic [SR_W-1:0] RISE_PRESET = 16'h7fff;
  localparam logic [SR_W-1:0] FALL_PRESET = 16'h0000;
  localparam logic [SR_W-1:0] MASK_PRESET = 16'h0000;

  localparam logic [STB_W-1:0] BYTE_ZERO = 8'h00;

  // ------------------------------------------------------------
  // status byte bit positions
  // ------------------------------------------------------------
  localparam int STB_ERR_BIT  = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_OUT_BIT  = 4;
  localparam int STB_STD_BIT  = 5;
  localparam int STB_TOP_BIT  = 6;
  localparam int STB_OPER_BIT = 7;

  // mask bits that may ever request service (bit 6 excluded)
  localparam logic [STB_W-1:0] REQ_USED = 8'hbf;

  // ------------------------------------------------------------
  // command port encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_CLEAR,
    OP_PRESET
  } ses_op_t;

  typedef enum logic [3:0] {
    SEL_OPER_COND,
    SEL_OPER_EVENT,
    SEL_OPER_RISE,
    SEL_OPER_FALL,
    SEL_OPER_MASK,
    SEL_QUES_COND,
    SEL_QUES_EVENT,
    SEL_QUES_RISE,
    SEL_QUES_FALL,
    SEL_QUES_MASK,
    SEL_STD_EVENT,
    SEL_STD_MASK,
    SEL_STATUS_BYTE,
    SEL_REQUEST_MASK
  } ses_sel_t;

endpackage

// ==== logic/ses_status_reg.sv ====
// five-part 16-bit status register with transition filters and sum bit
`timescale 1ns/100ps
module ses_status_reg
  import ses_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            sys_rst,
  input  wire logic [SR_W-1:0] cond_in,
  input  wire logic [SR_W-1:0] wdata,
  input  wire logic            wr_rise,
  input  wire logic            wr_fall,
  input  wire logic            wr_mask,
  input  wire logic            preset,
  input  wire logic            clear_event,
  output logic      [SR_W-1:0] cond,
  output logic      [SR_W-1:0] event_bits,
  output logic      [SR_W-1:0] rise_filter,
  output logic      [SR_W-1:0] fall_filter,
  output logic      [SR_W-1:0] sum_mask,
  output logic                 sum_bit
);

  logic [SR_W-1:0] cond_reg;
  logic [SR_W-1:0] prev_reg;
  logic [SR_W-1:0] event_reg;
  logic [SR_W-1:0] rise_reg;
  logic [SR_W-1:0] fall_reg;
  logic [SR_W-1:0] mask_reg;
  logic [SR_W-1:0] hits;

  // live state is hardware-only; no write path exists
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cond_reg <= SR_ZERO;
      prev_reg <= SR_ZERO;
    end else begin
      cond_reg <= cond_in & SR_USED;
      prev_reg <= cond_reg;
    end
  end

  assign hits = ((cond_reg & ~prev_reg & rise_reg)
               | (~cond_reg & prev_reg & fall_reg)) & SR_USED;

  // a hit in the read cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) event_reg <= SR_ZERO;
    else if (clear_event) event_reg <= hits;
    else event_reg <= event_reg | hits;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rise_reg <= SR_ZERO;
      fall_reg <= SR_ZERO;
      mask_reg <= SR_ZERO;
    end else if (preset) begin
      rise_reg <= RISE_PRESET;
      fall_reg <= FALL_PRESET;
      mask_reg <= MASK_PRESET;
    end else begin
      if (wr_rise) rise_reg <= wdata & SR_USED;
      if (wr_fall) fall_reg <= wdata & SR_USED;
      if (wr_mask) mask_reg <= wdata & SR_USED;
    end
  end

  assign cond        = cond_reg;
  assign event_bits  = event_reg;
  assign rise_filter = rise_reg;
  assign fall_filter = fall_reg;
  assign sum_mask    = mask_reg;
  assign sum_bit     = |(event_reg & mask_reg);

endmodule

// ==== logic/ses_std_event.sv ====
// 8-bit standard event latch with enable mask and summary
`timescale 1ns/100ps
module ses_std_event
  import ses_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [STD_W-1:0] event_set,
  input  wire logic [STD_W-1:0] wdata,
  input  wire logic             wr_mask,
  input  wire logic             clear_event,
  output logic      [STD_W-1:0] event_bits,
  output logic      [STD_W-1:0] event_mask,
  output logic                  sum_bit
);

  logic [STD_W-1:0] event_reg;
  logic [STD_W-1:0] mask_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) event_reg <= BYTE_ZERO;
    else if (clear_event) event_reg <= event_set;
    else event_reg <= event_reg | event_set;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) mask_reg <= BYTE_ZERO;
    else if (wr_mask) mask_reg <= wdata;
  end

  assign event_bits = event_reg;
  assign event_mask = mask_reg;
  assign sum_bit    = |(event_reg & mask_reg);

endmodule

// ==== verif/ses_status_monitor.sv ====
// concurrent checks on the status event summary top ports
`timescale 1ns/100ps
module ses_status_monitor
  import ses_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  input wire logic               error_pending,
  input wire logic               output_pending,
  input wire logic               cmd_valid,
  input wire ses_pkg::ses_op_t   cmd_op,
  input wire ses_pkg::ses_sel_t  cmd_sel,
  input wire logic               rsp_valid,
  input wire logic [SR_W-1:0]    rsp_data,
  input wire logic               poll_req,
  input wire logic               poll_valid,
  input wire logic [STB_W-1:0]   status_byte,
  input wire logic               service_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  read_answer_a: assert property (cmd_valid && cmd_op == OP_READ |=> rsp_valid)
    else $error("read not answered");
  stray_rsp_a: assert property (rsp_valid |-> $past(cmd_valid && cmd_op == OP_READ))
    else $error("answer without read");
  rsp_held_a: assert property (!$past(cmd_valid && cmd_op == OP_READ) |-> $stable(rsp_data))
    else $error("read data moved without read");
  poll_answer_a: assert property (poll_req |=> poll_valid)
    else $error("poll not answered");
  top_bit15_a: assert property (rsp_valid |-> !rsp_data[15])
    else $error("bit 15 read as one");
  mask_bit6_a: assert property (cmd_valid && cmd_op == OP_READ && cmd_sel == SEL_REQUEST_MASK
    |=> !rsp_data[6] && rsp_data[15:8] == 8'h00)
    else $error("request mask bit 6 stored");
  top_summary_a: assert property (status_byte[STB_TOP_BIT] |-> |(status_byte & REQ_USED))
    else $error("summary bit without cause");
  srq_cause_a: assert property (service_req |-> status_byte[STB_TOP_BIT])
    else $error("request without enabled bit");
  pending_bit_a: assert property (output_pending [*4] |-> status_byte[STB_OUT_BIT])
    else $error("output pending bit missing");
  error_bit_a: assert property (!error_pending [*4] |-> !status_byte[STB_ERR_BIT])
    else $error("error bit set without entry");
endmodule

bind ses_status_top ses_status_monitor mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .error_pending(error_pending), .output_pending(output_pending), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_sel(cmd_sel), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .poll_req(poll_req), .poll_valid(poll_valid), .status_byte(status_byte), .service_req(service_req));

// ==== verif/ses_ctl_model.sv ====
// remote controller model: commands, serial poll, request counting
`timescale 1ns/100ps
module ses_ctl_model
  import ses_pkg::*;
(
  input  wire logic              ref_clk,
  output logic                   cmd_valid,
  output ses_pkg::ses_op_t       cmd_op,
  output ses_pkg::ses_sel_t      cmd_sel,
  output logic      [SR_W-1:0]   cmd_wdata,
  input  wire logic              rsp_valid,
  input  wire logic [SR_W-1:0]   rsp_data,
  output logic                   poll_req,
  input  wire logic              poll_valid,
  input  wire logic [STB_W-1:0]  poll_data,
  input  wire logic              service_req
);
  int srq_count = 0;

  initial begin
    cmd_valid = 1'b0;
    cmd_op    = OP_READ;
    cmd_sel   = SEL_OPER_COND;
    cmd_wdata = 16'h0000;
    poll_req  = 1'b0;
  end

  always @(posedge ref_clk) begin
    if (service_req === 1'b1) srq_count++;
  end

  // one command; the answer stands only in the cycle after the strobe edge
  task automatic cmd(input ses_op_t op, input ses_sel_t sel, input logic [SR_W-1:0] wd,
                     output logic [SR_W-1:0] rd);
    @(negedge ref_clk);
    cmd_op    = op;
    cmd_sel   = sel;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    rd = (rsp_valid === 1'b1) ? rsp_data : 'x;
    cmd_valid = 1'b0;
    // bus left holding the inverse of the written data
    cmd_wdata = ~wd;
  endtask

  task automatic poll(output logic [STB_W-1:0] pd);
    @(negedge ref_clk);
    poll_req = 1'b1;
    @(negedge ref_clk);
    pd = (poll_valid === 1'b1) ? poll_data : 'x;
    poll_req = 1'b0;
  endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the status event summary block
`timescale 1ns/100ps
module tb_top;
  import ses_pkg::*;
  typedef struct {ses_op_t op; ses_sel_t sel; logic [15:0] v;} ses_row_t;
  logic              ref_clk, sys_rst, error_pending, output_pending;
  logic              cmd_valid, rsp_valid, poll_req, poll_valid, service_req;
  logic [SR_W-1:0]   oper_hw, ques_hw, cmd_wdata, rsp_data, d;
  logic [STB_W-1:0]  std_event_set, poll_data, status_byte, pd;
  ses_op_t           cmd_op;
  ses_sel_t          cmd_sel;
  int                n_errors = 0, num_checks = 0, cyc = 0, s;
  // read rows carry the expected value in place of write data
  ses_row_t rows [20] = '{
    '{OP_WRITE, SEL_OPER_RISE, 16'hffff}, '{OP_READ, SEL_OPER_RISE, 16'h7fff},
    '{OP_WRITE, SEL_OPER_FALL, 16'h1234}, '{OP_READ, SEL_OPER_FALL, 16'h1234},
    '{OP_READ, SEL_OPER_FALL, 16'h1234}, '{OP_WRITE, SEL_OPER_MASK, 16'h8001},
    '{OP_READ, SEL_OPER_MASK, 16'h0001}, '{OP_WRITE, SEL_QUES_FALL, 16'hffff},
    '{OP_READ, SEL_QUES_FALL, 16'h7fff}, '{OP_WRITE, SEL_STD_MASK, 16'h00ff},
    '{OP_READ, SEL_STD_MASK, 16'h00ff}, '{OP_WRITE, SEL_REQUEST_MASK, 16'h00ff},
    '{OP_READ, SEL_REQUEST_MASK, 16'h00bf}, '{OP_WRITE, SEL_OPER_COND, 16'h00ff},
    '{OP_READ, SEL_OPER_COND, 16'h0000}, '{OP_WRITE, SEL_OPER_EVENT, 16'h00ff},
    '{OP_READ, SEL_OPER_EVENT, 16'h0000}, '{OP_WRITE, SEL_QUES_RISE, 16'h8421},
    '{OP_READ, SEL_QUES_RISE, 16'h0421}, '{OP_READ, SEL_QUES_COND, 16'h0000}};

  ses_status_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .oper_hw(oper_hw), .ques_hw(ques_hw),
    .std_event_set(std_event_set), .error_pending(error_pending), .output_pending(output_pending),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .poll_req(poll_req), .poll_valid(poll_valid),
    .poll_data(poll_data), .status_byte(status_byte), .service_req(service_req));
  ses_ctl_model ctl (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .poll_req(poll_req),
    .poll_valid(poll_valid), .poll_data(poll_data), .service_req(service_req));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic results;
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input ses_sel_t sel, input logic [15:0] exp);
    ctl.cmd(OP_READ, sel, 16'h0000, d);
    chk(d, exp, sel.name());
  endtask
  task automatic wr(input ses_sel_t sel, input logic [15:0] v);
    ctl.cmd(OP_WRITE, sel, v, d);
  endtask
  // bounded wait for a status byte bit, then compare
  task automatic wb(input int b, input logic v);
    int n;
    n = 0;
    while (status_byte[b] !== v && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk({15'h0000, status_byte[b]}, {15'h0000, v}, "status bit");
  endtask
  task automatic srq(input int n);
    repeat (2) @(negedge ref_clk);
    chk(16'(ctl.srq_count), 16'(n), "requests");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {error_pending, output_pending} = 2'b00;
    {oper_hw, ques_hw, std_event_set} = 40'h00_0000_0000;
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].op == OP_READ) rd(rows[i].sel, rows[i].v);
      else ctl.cmd(rows[i].op, rows[i].sel, rows[i].v, d);
    end
    wr(SEL_OPER_RISE, 16'h0001);
    wr(SEL_OPER_FALL, 16'h0002);
    wr(SEL_OPER_MASK, 16'h0003);
    oper_hw = 16'h8003;
    wb(7, 1'b1);
    rd(SEL_OPER_COND, 16'h0003);
    rd(SEL_OPER_COND, 16'h0003);
    rd(SEL_OPER_EVENT, 16'h0001);
    rd(SEL_OPER_EVENT, 16'h0000);
    wb(7, 1'b0);
    oper_hw = 16'h0000;
    wb(7, 1'b1);
    rd(SEL_OPER_EVENT, 16'h0002);
    wr(SEL_REQUEST_MASK, 16'h0080);
    s = ctl.srq_count;
    oper_hw = 16'h0001;
    wb(7, 1'b1);
    srq(s + 1);
    ctl.poll(pd);
    chk({8'h00, pd}, 16'h00c0, "poll");
    rd(SEL_STATUS_BYTE, 16'h00c0);
    output_pending = 1'b1;
    wb(4, 1'b1);
    srq(s + 1);
    rd(SEL_OPER_EVENT, 16'h0001);
    output_pending = 1'b0;
    wb(4, 1'b0);
    // error entries enabled, as a controller should
    wr(SEL_REQUEST_MASK, 16'h0014);
    error_pending = 1'b1;
    wb(2, 1'b1);
    srq(s + 2);
    output_pending = 1'b1;
    wb(4, 1'b1);
    srq(s + 3);
    {error_pending, output_pending} = 2'b00;
    std_event_set = 8'h01;
    @(negedge ref_clk);
    std_event_set = 8'h00;
    wb(5, 1'b1);
    rd(SEL_STD_EVENT, 16'h0001);
    wb(5, 1'b0);
    wr(SEL_QUES_RISE, 16'h0004);
    wr(SEL_QUES_MASK, 16'h0004);
    ques_hw = 16'h0004;
    wb(3, 1'b1);
    ctl.cmd(OP_CLEAR, SEL_OPER_COND, 16'h0000, d);
    wb(3, 1'b0);
    rd(SEL_QUES_EVENT, 16'h0000);
    ctl.cmd(OP_PRESET, SEL_OPER_COND, 16'h0000, d);
    rd(SEL_OPER_RISE, RISE_PRESET);
    rd(SEL_QUES_MASK, MASK_PRESET);
    oper_hw = 16'h0003;
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({8'h00, status_byte}, 16'h0000, "reset byte");
    sys_rst = 1'b0;
    rd(SEL_OPER_RISE, 16'h0000);
    rd(SEL_REQUEST_MASK, 16'h0000);
    results();
  end
endmodule
